/* par_buzzer.sv */
`timescale 1ns/10ps
`default_nettype none

// Load on the relay contact: sounds while closed, records each closure
module par_buzzer (
   input  wire logic        i_core_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_contact,
   output logic      [15:0] o_last_on,
   output logic      [7:0]  o_closures
);
   logic [15:0] run;
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         {run, o_last_on, o_closures} <= '0;
      end else if (i_contact) begin
         run <= run + 16'h0001;
      end else begin
         if (run != 16'h0000) begin
            o_last_on <= run;
            o_closures <= o_closures + 8'h01;
         end
         run <= '0;
      end
   end
endmodule // par_buzzer

`default_nettype wire

/* par_pkg.sv */
package par_pkg;

   // APB register offsets (one word per register, channel B at +0x20)
   localparam logic [7:0] REG_CTRL_A     = 8'h00;
   localparam logic [7:0] REG_HIGH_A     = 8'h04;
   localparam logic [7:0] REG_LOW_A      = 8'h08;
   localparam logic [7:0] REG_BAND_A     = 8'h0C;
   localparam logic [7:0] REG_PULSE_A    = 8'h10;
   localparam logic [7:0] CHAN_STRIDE    = 8'h20;
   localparam logic [7:0] REG_TEMP       = 8'h40;
   localparam logic [7:0] REG_STATUS     = 8'h44;
   localparam logic [7:0] REG_IRQ_STAT   = 8'h48;
   localparam logic [7:0] REG_IRQ_MASK   = 8'h4C;

   // Control and limit register field positions
   localparam int CTRL_FUNC_LSB          = 0;
   localparam int CTRL_ONE_SHOT_BIT      = 4;
   localparam int CTRL_SUPPRESS_BIT      = 5;
   localparam int CTRL_OPEN_ON_TRIP_BIT  = 6;
   localparam int LIMIT_ON_BIT           = 16;

   // Relay function codes
   localparam logic [2:0] FUNC_OFF          = 3'h0;
   localparam logic [2:0] FUNC_PROCESS_TRIP = 3'h1;

   // Reset values and clamp limits; temperatures and band in tenths of a degree
   localparam logic [15:0] BAND_RESET    = 16'h0003;
   localparam logic [15:0] BAND_MIN      = 16'h0001;
   localparam logic [15:0] BAND_MAX      = 16'h03E8;
   localparam logic [6:0]  PULSE_RESET   = 7'h05;
   localparam logic [6:0]  PULSE_MIN     = 7'h01;
   localparam logic [6:0]  PULSE_MAX     = 7'h64;

   // Time base
   localparam int CLK_HZ                 = 10_000_000;
   localparam int SECOND_S               = 1;
   localparam int SECOND_CYCLES          = CLK_HZ * SECOND_S;

endpackage : par_pkg

/* par_relay.sv */
// Function
// [R01] Action, suppression, limits, band and pulse length act only when the relay function is process trip; code updates armed in every function.
// [R02] In one-shot action a rising trip condition drives the relay active for one pulse of the programmed length.
// [R03] In follow action the relay is active exactly while the trip condition holds.
// [R04] With suppression on and the low limit enabled, the relay stays inactive until temperature exceeds low limit plus band; code gates only the low trip.
// [R05] Once temperature has exceeded low limit plus band, suppression is cancelled for good.
// [R06] High trip sets above the high limit and clears only below high limit minus band.
// [R07] Low trip sets below the low limit and clears only above low limit plus band.
// [R08] Either limit may be switched off, and that side is then ignored.
// [R09] Software keeps the low limit below the high limit, otherwise the relay stays active.
// [R10] Two independent channels, each with its own settings and relay.
// [R11] Pulse length is whole seconds from 1 to 100 and times the one-shot output.
// [R12] Close-on-trip contact is open while inactive; open-on-trip contact is closed while inactive.
// [R13] Band is 0.1 to 100.0 degrees with 0.3 after reset.
// [R14] Pulse length defaults to 5 seconds within 1 to 100.
// [R15] The channel trip is the OR of high and low trips, and a one-shot fires on its rising edge.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module par_relay #(
   parameter int SECOND_CYCLES = par_pkg::SECOND_CYCLES
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic [15:0] i_measured_temp,
   output logic      [1:0]  o_relay_contact,
   output logic             o_irq
);

   // Refuse a rate that the 24-bit second counter cannot time
   if (SECOND_CYCLES < 2 || SECOND_CYCLES > (1 << 24)) begin : g_bad_rate
      $error("SECOND_CYCLES must be 2 to 16777216");
   end

   localparam int NCH = 2;

   typedef enum logic [2:0] {
      PAR_IDLE  = 3'b001,
      PAR_PULSE = 3'b010,
      PAR_WAIT  = 3'b100
   } par_shot_t;

   // Configuration per channel
   logic [2:0]  func      [NCH];
   logic        one_shot  [NCH];
   logic        suppress  [NCH];
   logic        open_trip [NCH];
   logic [15:0] high_lim  [NCH];
   logic        high_on   [NCH];
   logic [15:0] low_lim   [NCH];
   logic        low_on    [NCH];
   logic [15:0] band      [NCH];
   logic [6:0]  pulse_len [NCH];
   logic [3:0]  irq_stat;
   logic [3:0]  irq_mask;
   logic [31:0] prdata;

   logic [2:0]  next_func      [NCH];
   logic        next_one_shot  [NCH];
   logic        next_suppress  [NCH];
   logic        next_open_trip [NCH];
   logic [15:0] next_high_lim  [NCH];
   logic        next_high_on   [NCH];
   logic [15:0] next_low_lim   [NCH];
   logic        next_low_on    [NCH];
   logic [15:0] next_band      [NCH];
   logic [6:0]  next_pulse_len [NCH];
   logic [3:0]  next_irq_stat;
   logic [3:0]  next_irq_mask;
   logic [31:0] next_prdata;

   // Trip state per channel
   logic        high_trip  [NCH];
   logic        low_trip   [NCH];
   logic        armed      [NCH];
   logic        active     [NCH];
   par_shot_t   shot       [NCH];
   logic [6:0]  secs       [NCH];
   logic [1:0]  contact;

   logic        next_high_trip [NCH];
   logic        next_low_trip  [NCH];
   logic        next_armed     [NCH];
   logic        next_active    [NCH];
   par_shot_t   next_shot      [NCH];
   logic [6:0]  next_secs      [NCH];
   logic [1:0]  next_contact;

   logic [23:0] tick_cnt;
   logic [23:0] next_tick_cnt;
   logic        tick;

   logic        wr;
   logic        rd;
   logic [3:0]  events;

   function automatic logic [15:0] clamp_band(input logic [15:0] v);
      if (v < par_pkg::BAND_MIN) return par_pkg::BAND_MIN;
      if (v > par_pkg::BAND_MAX) return par_pkg::BAND_MAX;
      return v;
   endfunction

   function automatic logic [6:0] clamp_pulse(input logic [6:0] v);
      if (v < par_pkg::PULSE_MIN) return par_pkg::PULSE_MIN;
      if (v > par_pkg::PULSE_MAX) return par_pkg::PULSE_MAX;
      return v;
   endfunction

   assign wr        = i_psel && i_penable && i_pwrite;
   assign rd        = i_psel && !i_penable && !i_pwrite;
   assign o_pready  = 1'b1;
   assign o_pslverr = 1'b0;
   assign o_prdata  = prdata;
   assign tick      = (tick_cnt == 24'(SECOND_CYCLES - 1));

   // One-second enable
   always_comb begin
      next_tick_cnt = tick ? 24'h000000 : tick_cnt + 24'h000001;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         tick_cnt <= 24'h000000;
      end else begin
         tick_cnt <= next_tick_cnt;
      end
   end

   // Register file and read mux
   always_comb begin
      logic [7:0] a;
      a             = 8'h00;
      next_irq_stat = irq_stat | events;
      next_irq_mask = irq_mask;
      next_prdata   = prdata;
      for (int c = 0; c < NCH; c++) begin
         next_func[c]      = func[c];
         next_one_shot[c]  = one_shot[c];
         next_suppress[c]  = suppress[c];
         next_open_trip[c] = open_trip[c];
         next_high_lim[c]  = high_lim[c];
         next_high_on[c]   = high_on[c];
         next_low_lim[c]   = low_lim[c];
         next_low_on[c]    = low_on[c];
         next_band[c]      = band[c];
         next_pulse_len[c] = pulse_len[c];
         a = i_paddr - 8'(c * par_pkg::CHAN_STRIDE);
         if (wr) begin
            if (a == par_pkg::REG_CTRL_A) begin
               next_func[c]      = i_pwdata[par_pkg::CTRL_FUNC_LSB +: 3];
               next_one_shot[c]  = i_pwdata[par_pkg::CTRL_ONE_SHOT_BIT];
               next_suppress[c]  = i_pwdata[par_pkg::CTRL_SUPPRESS_BIT];
               next_open_trip[c] = i_pwdata[par_pkg::CTRL_OPEN_ON_TRIP_BIT];
            end else if (a == par_pkg::REG_HIGH_A) begin
               next_high_lim[c]  = i_pwdata[15:0];
               next_high_on[c]   = i_pwdata[par_pkg::LIMIT_ON_BIT];
            end else if (a == par_pkg::REG_LOW_A) begin
               next_low_lim[c]   = i_pwdata[15:0];
               next_low_on[c]    = i_pwdata[par_pkg::LIMIT_ON_BIT];
            end else if (a == par_pkg::REG_BAND_A) begin
               next_band[c]      = clamp_band(i_pwdata[15:0]); // [R13]
            end else if (a == par_pkg::REG_PULSE_A) begin
               next_pulse_len[c] = clamp_pulse(i_pwdata[6:0]); // [R11] [R14]
            end
         end
         if (rd) begin
            if (a == par_pkg::REG_CTRL_A) begin
               next_prdata = {25'h0, open_trip[c], suppress[c], one_shot[c], 1'b0, func[c]};
            end else if (a == par_pkg::REG_HIGH_A) begin
               next_prdata = {15'h0, high_on[c], high_lim[c]};
            end else if (a == par_pkg::REG_LOW_A) begin
               next_prdata = {15'h0, low_on[c], low_lim[c]};
            end else if (a == par_pkg::REG_BAND_A) begin
               next_prdata = {16'h0, band[c]};
            end else if (a == par_pkg::REG_PULSE_A) begin
               next_prdata = {25'h0, pulse_len[c]};
            end
         end
      end
      if (rd) begin
         if (i_paddr == par_pkg::REG_TEMP) begin
            next_prdata = {16'h0, i_measured_temp};
         end else if (i_paddr == par_pkg::REG_STATUS) begin
            next_prdata = {22'h0, contact, armed[1], armed[0], low_trip[1], low_trip[0],
                           high_trip[1], high_trip[0], active[1], active[0]};
         end else if (i_paddr == par_pkg::REG_IRQ_STAT) begin
            next_prdata = {28'h0, irq_stat};
         end else if (i_paddr == par_pkg::REG_IRQ_MASK) begin
            next_prdata = {28'h0, irq_mask};
         end else if (i_paddr[7:6] != 2'b00) begin
            next_prdata = 32'h00000000;
         end
      end
      if (wr && i_paddr == par_pkg::REG_IRQ_MASK) begin
         next_irq_mask = i_pwdata[3:0];
      end
      // Set wins over write-one-to-clear
      if (wr && i_paddr == par_pkg::REG_IRQ_STAT) begin
         next_irq_stat = (irq_stat & ~i_pwdata[3:0]) | events;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         irq_stat <= 4'h0;
         irq_mask <= 4'h0;
         prdata   <= 32'h00000000;
         for (int c = 0; c < NCH; c++) begin
            func[c]      <= par_pkg::FUNC_OFF;
            one_shot[c]  <= 1'b0;
            suppress[c]  <= 1'b0;
            open_trip[c] <= 1'b0;
            high_lim[c]  <= 16'h0000;
            high_on[c]   <= 1'b0;
            low_lim[c]   <= 16'h0000;
            low_on[c]    <= 1'b0;
            band[c]      <= par_pkg::BAND_RESET; // [R13]
            pulse_len[c] <= par_pkg::PULSE_RESET; // [R14]
         end
      end else begin
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         prdata   <= next_prdata;
         for (int c = 0; c < NCH; c++) begin
            func[c]      <= next_func[c];
            one_shot[c]  <= next_one_shot[c];
            suppress[c]  <= next_suppress[c];
            open_trip[c] <= next_open_trip[c];
            high_lim[c]  <= next_high_lim[c];
            high_on[c]   <= next_high_on[c];
            low_lim[c]   <= next_low_lim[c];
            low_on[c]    <= next_low_on[c];
            band[c]      <= next_band[c];
            pulse_len[c] <= next_pulse_len[c];
         end
      end
   end

   assign o_irq = |(irq_stat & irq_mask);

   // Trip logic, one copy per channel
   always_comb begin
      logic [16:0] t;
      logic [16:0] hi_clr;
      logic [16:0] lo_clr;
      logic        en;
      logic        trip;
      logic        was;
      t            = {1'b0, i_measured_temp};
      hi_clr       = 17'h00000;
      lo_clr       = 17'h00000;
      en           = 1'b0;
      trip         = 1'b0;
      was          = 1'b0;
      events       = 4'h0;
      next_contact = contact;
      for (int c = 0; c < NCH; c++) begin // [R10]
         en     = (func[c] == par_pkg::FUNC_PROCESS_TRIP); // [R01]
         hi_clr = {1'b0, high_lim[c]} - {1'b0, band[c]};
         lo_clr = {1'b0, low_lim[c]} + {1'b0, band[c]};
         next_high_trip[c] = high_trip[c];
         next_low_trip[c]  = low_trip[c];
         if (!en || !high_on[c]) begin // [R08]
            next_high_trip[c] = 1'b0;
         end else if (t > {1'b0, high_lim[c]}) begin // [R06]
            next_high_trip[c] = 1'b1;
         end else if (!hi_clr[16] && t < hi_clr) begin // [R06]
            next_high_trip[c] = 1'b0;
         end
         if (!en || !low_on[c]) begin // [R08]
            next_low_trip[c] = 1'b0;
         end else if (t < {1'b0, low_lim[c]}) begin // [R07]
            next_low_trip[c] = 1'b1;
         end else if (t > lo_clr) begin // [R07]
            next_low_trip[c] = 1'b0;
         end
         next_armed[c] = armed[c] || (t > lo_clr); // [R05]
         trip = high_trip[c] || (low_trip[c] && !(suppress[c] && low_on[c] && !armed[c])); // [R15] [R04] [R09]
         was  = active[c];
         next_shot[c]   = shot[c];
         next_secs[c]   = secs[c];
         next_active[c] = 1'b0;
         if (!en) begin
            next_shot[c] = PAR_IDLE;
         end else if (!one_shot[c]) begin
            next_active[c] = trip; // [R03]
            next_shot[c]   = trip ? PAR_WAIT : PAR_IDLE;
         end else begin
            case (shot[c])
               PAR_IDLE: begin
                  if (trip) begin // [R15]
                     next_shot[c]   = PAR_PULSE;
                     next_secs[c]   = pulse_len[c];
                     next_active[c] = 1'b1; // [R02]
                  end
               end
               PAR_PULSE: begin
                  next_active[c] = 1'b1; // [R02]
                  if (tick) begin
                     next_secs[c] = secs[c] - 7'h01; // [R11]
                     if (secs[c] == 7'h01) begin
                        next_shot[c]   = PAR_WAIT;
                        next_active[c] = 1'b0;
                     end
                  end
               end
               PAR_WAIT: begin
                  if (!trip) begin
                     next_shot[c] = PAR_IDLE;
                  end
               end
               default: next_shot[c] = PAR_IDLE;
            endcase
         end
         next_contact[c] = next_active[c] ^ open_trip[c]; // [R12]
         events[c]       = next_active[c] && !was;
         events[c + 2]   = !next_active[c] && was;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         contact <= 2'b00;
         for (int c = 0; c < NCH; c++) begin
            high_trip[c] <= 1'b0;
            low_trip[c]  <= 1'b0;
            armed[c]     <= 1'b0; // [R04]
            active[c]    <= 1'b0;
            shot[c]      <= PAR_IDLE;
            secs[c]      <= 7'h00;
         end
      end else begin
         contact <= next_contact;
         for (int c = 0; c < NCH; c++) begin
            high_trip[c] <= next_high_trip[c];
            low_trip[c]  <= next_low_trip[c];
            armed[c]     <= next_armed[c];
            active[c]    <= next_active[c];
            shot[c]      <= next_shot[c];
            secs[c]      <= next_secs[c];
         end
      end
   end

   assign o_relay_contact = contact;

endmodule : par_relay
`default_nettype wire

/* par_relay_props.sv */
`timescale 1ns/10ps
`default_nettype none

module par_relay_chk #(
   parameter int SECOND_CYCLES = par_pkg::SECOND_CYCLES
) (
   input wire logic        i_core_clk,
   input wire logic        i_reset_n,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [7:0]  i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic [15:0] i_measured_temp,
   input wire logic [1:0]  o_relay_contact,
   input wire logic        o_irq
);
   logic [2:0]  sh_func;
   logic        sh_shot, sh_supp, sh_open, sh_hi_en, sh_lo_en;
   logic [15:0] sh_hi, sh_lo, on_cnt;
   logic [6:0]  sh_pulse;
   logic [3:0]  sh_mask;
   logic        wr;
   logic        proc;
   assign wr = i_psel && i_penable && i_pwrite;
   assign proc = sh_func == par_pkg::FUNC_PROCESS_TRIP;

   // Shadow of channel A settings, taken from bus writes
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         {sh_func, sh_shot, sh_supp, sh_open, sh_hi_en, sh_lo_en, sh_hi, sh_lo, sh_mask} <= '0;
         sh_pulse <= par_pkg::PULSE_RESET;
      end else if (wr) begin
         if (i_paddr == par_pkg::REG_CTRL_A) {sh_open, sh_supp, sh_shot, sh_func} <= {i_pwdata[6:4], i_pwdata[2:0]};
         if (i_paddr == par_pkg::REG_HIGH_A) {sh_hi_en, sh_hi} <= i_pwdata[16:0];
         if (i_paddr == par_pkg::REG_LOW_A) {sh_lo_en, sh_lo} <= i_pwdata[16:0];
         if (i_paddr == par_pkg::REG_PULSE_A) begin
            if (i_pwdata[6:0] < par_pkg::PULSE_MIN) sh_pulse <= par_pkg::PULSE_MIN;
            else if (i_pwdata[6:0] > par_pkg::PULSE_MAX) sh_pulse <= par_pkg::PULSE_MAX;
            else sh_pulse <= i_pwdata[6:0];
         end
         if (i_paddr == par_pkg::REG_IRQ_MASK) sh_mask <= i_pwdata[3:0];
      end
   end

   // Length of the current closure of contact A
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n || !o_relay_contact[0]) on_cnt <= '0;
      else on_cnt <= on_cnt + 16'h0001;
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);

   sequence s_hi_held;
      (proc && !sh_shot && sh_hi_en && !sh_lo_en && i_measured_temp > sh_hi)[*3];
   endsequence
   sequence s_lo_held;
      (proc && !sh_shot && !sh_supp && !sh_hi_en && sh_lo_en && i_measured_temp < sh_lo)[*3];
   endsequence

   a_ready_high: assert property (o_pready) else $error("pready low");
   a_error_low: assert property (!o_pslverr) else $error("pslverr high");
   a_rdata_stands: assert property (i_psel && i_penable |=> $stable(o_prdata)) else $error("prdata moved");
   a_off_open: assert property ((!proc)[*3] |-> !o_relay_contact[0]) else $error("contact active when off");
   a_high_trip: assert property (s_hi_held |-> o_relay_contact[0] == !sh_open) else $error("high trip");
   a_low_trip: assert property (s_lo_held |-> o_relay_contact[0] == !sh_open) else $error("low trip");
   a_pulse_len: assert property (proc && sh_shot && !sh_open && $fell(o_relay_contact[0]) |->
      int'(on_cnt) >= (int'(sh_pulse) - 1) * SECOND_CYCLES && int'(on_cnt) <= int'(sh_pulse) * SECOND_CYCLES + 2)
      else $error("pulse length");
   a_irq_masked: assert property ((sh_mask == 4'h0)[*2] |-> !o_irq) else $error("masked irq"); 
   a_irq_event: assert property ($rose(o_relay_contact[0]) && proc && !sh_open && !$past(sh_open, 2) && sh_mask[0]
      |-> ##[0:2] o_irq) else $error("irq missing");
endmodule // par_relay_chk

bind par_relay par_relay_chk #(.SECOND_CYCLES(SECOND_CYCLES)) par_relay_chk_inst (
   .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
   .o_pslverr(o_pslverr), .i_measured_temp(i_measured_temp), .o_relay_contact(o_relay_contact), .o_irq(o_irq));

`default_nettype wire

/* par_relay_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module par_relay_tb;
   localparam int SC = 10;
   logic        i_core_clk, i_reset_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq;
   logic [7:0]  i_paddr, buz_count, base;
   logic [31:0] i_pwdata, o_prdata, rdat;
   logic [15:0] i_measured_temp, buz_last;
   logic [1:0]  o_relay_contact;
   int          fails, check_count;
   localparam logic [7:0] CB = par_pkg::CHAN_STRIDE;

   par_relay #(.SECOND_CYCLES(SC)) par_relay_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_measured_temp(i_measured_temp),
      .o_relay_contact(o_relay_contact), .o_irq(o_irq));
   par_buzzer par_buzzer_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_contact(o_relay_contact[0]),
      .o_last_on(buz_last), .o_closures(buz_count));

   initial begin
      i_core_clk = 1'h0;
      forever #50 i_core_clk = ~i_core_clk;
   end

   task automatic end_sim;
      if (fails == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'h1, 1'h0, w, a, d};
      @(posedge i_core_clk);
      i_penable <= 1'h1;
      do begin
         @(posedge i_core_clk);
      end while (o_pready !== 1'h1);
      rdat = o_prdata;
      {i_psel, i_penable} <= 2'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      apb(1'h0, a, 32'h0);
      chk(nm, rdat, exp);
   endtask
   task automatic step(input logic [15:0] t, input logic [1:0] exp);
      @(posedge i_core_clk);
      i_measured_temp <= t;
      repeat (4) @(posedge i_core_clk);
      @(negedge i_core_clk);
      chk("contact", {30'h0, o_relay_contact}, {30'h0, exp});
   endtask
   task automatic wait_count(input logic [7:0] target);
      int k;
      k = 0;
      while (buz_count !== target && k < 200) begin
         @(posedge i_core_clk);
         k++;
      end
      chk("closures", {24'h0, buz_count}, {24'h0, target});
   endtask

   initial begin
      repeat (20000) @(posedge i_core_clk);
      fails++;
      end_sim();
   end

   initial begin
      {fails, check_count} = '0;
      {i_reset_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_measured_temp} = '0;
      repeat (12) @(posedge i_core_clk);
      i_reset_n <= 1'h1;
      rd(par_pkg::REG_BAND_A, 32'h3, "band_a");
      rd(par_pkg::REG_PULSE_A, 32'h5, "pulse_a");
      rd(par_pkg::REG_BAND_A + CB, 32'h3, "band_b");
      rd(par_pkg::REG_PULSE_A + CB, 32'h5, "pulse_b");
      rd(8'h80, 32'h0, "unmapped");
      wr(par_pkg::REG_LOW_A + CB, 32'h101F4);
      wr(par_pkg::REG_CTRL_A + CB, 32'h21);
      step(16'h0064, 2'h0);
      step(16'h01F8, 2'h0);
      step(16'h0064, 2'h2);
      wr(par_pkg::REG_CTRL_A + CB, 32'h0);
      step(16'h0064, 2'h0);
      wr(par_pkg::REG_IRQ_MASK, 32'h1);
      wr(par_pkg::REG_HIGH_A, 32'h103E8);
      wr(par_pkg::REG_BAND_A, 32'h1E);
      wr(par_pkg::REG_CTRL_A, 32'h1);
      step(16'h03E9, 2'h1);
      chk("irq", {31'h0, o_irq}, 32'h1);
      rd(par_pkg::REG_TEMP, 32'h3E9, "temp");
      rd(par_pkg::REG_STATUS, 32'h1C5, "status");
      step(16'h03D4, 2'h1);
      step(16'h03C9, 2'h0);
      rd(par_pkg::REG_IRQ_STAT, 32'hF, "irq_stat");
      wr(par_pkg::REG_IRQ_STAT, 32'hF);
      rd(par_pkg::REG_IRQ_STAT, 32'h0, "irq_stat");
      chk("irq", {31'h0, o_irq}, 32'h0);
      wr(par_pkg::REG_IRQ_MASK, 32'h0);
      wr(par_pkg::REG_HIGH_A, 32'h0);
      wr(par_pkg::REG_LOW_A, 32'h101F4);
      step(16'h01F3, 2'h1);
      step(16'h0208, 2'h1);
      step(16'h0213, 2'h0);
      wr(par_pkg::REG_HIGH_A, 32'h103E8);
      step(16'h03E9, 2'h1);
      step(16'h02BC, 2'h0);
      step(16'h0190, 2'h1);
      step(16'h02BC, 2'h0);
      wr(par_pkg::REG_CTRL_A, 32'h41);
      step(16'h02BC, 2'h1);
      step(16'h0190, 2'h0);
      wr(par_pkg::REG_CTRL_A, 32'h1);
      wr(par_pkg::REG_LOW_A, 32'h10320);
      wr(par_pkg::REG_HIGH_A, 32'h10258);
      step(16'h02BC, 2'h1);
      wr(par_pkg::REG_CTRL_A, 32'h0);
      step(16'h02BC, 2'h0);
      wr(par_pkg::REG_PULSE_A, 32'h0);
      rd(par_pkg::REG_PULSE_A, 32'h1, "pulse_min");
      wr(par_pkg::REG_PULSE_A, 32'h65);
      rd(par_pkg::REG_PULSE_A, 32'h64, "pulse_max");
      wr(par_pkg::REG_HIGH_A, 32'h0);
      wr(par_pkg::REG_LOW_A, 32'h101F4);
      wr(par_pkg::REG_PULSE_A, 32'h2);
      wr(par_pkg::REG_CTRL_A, 32'h11);
      base = buz_count;
      step(16'h0190, 2'h1);
      wait_count(base + 8'h01);
      chk("pulse_len", {31'h0, (buz_last >= 16'(SC) && buz_last <= 16'(2 * SC + 2))}, 32'h1);
      step(16'h0190, 2'h0);
      step(16'h02BC, 2'h0);
      step(16'h0190, 2'h1);
      wait_count(base + 8'h02);
      chk("pulse_len", {31'h0, (buz_last >= 16'(SC) && buz_last <= 16'(2 * SC + 2))}, 32'h1);
      end_sim();
   end
endmodule // par_relay_tb

`default_nettype wire
